// *** adc_bus_pkg.sv ***
package adc_bus_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RES_W  = 18;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int CFG_W  = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_RESULT = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_PINS   = 12'h00c;

  // ----------------------------------------------------------------
  // Serial configuration register fields
  // ----------------------------------------------------------------
  localparam int CFG_REF_PD = 0;
  localparam int CFG_BUF_PD = 1;
  localparam int CFG_CODING = 2;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int ST_MODE_LSB   = 0;
  localparam int ST_BUS_EN     = 2;
  localparam int ST_REF_EN     = 3;
  localparam int ST_BUF_EN     = 4;
  localparam int ST_SW_CFG     = 5;
  localparam int ST_ABORT      = 6;
  localparam int ST_BUF_MISUSE = 7;
  localparam int ST_CODING     = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [RES_W-1:0] RESULT_RST = 18'h00000;
  localparam logic [CFG_W-1:0] CFG_RST    = 3'h0;
  localparam logic [RES_W-1:0] OE_N_RST   = 18'h3ffff;

  // ----------------------------------------------------------------
  // Interface modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PAR18  = 2'h0;
  localparam logic [1:0] MODE_WORD16 = 2'h1;
  localparam logic [1:0] MODE_BYTE8  = 2'h2;
  localparam logic [1:0] MODE_SERIAL = 2'h3;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** adc_output_bus_mux.sv ***
// Function
// - Mode 0 drives all eighteen lines, line n carries result bit n.
// - Mode 1: line 0 coding, line 1 word select; high or low word.
// - Mode 2: lines 1-2 pick byte on lines 10-17; lines 3-9 released.
// - Mode 3: lines 0-1 inputs, line 2 released, upper lines for serial.
// - Mode 3 with software config: settings come from config register.
// - Internal reference on while its power-down input is low.
// - Bus driven only while read strobe and chip select are both low.
// - Reset pin falling edge clears result and config registers; high aborts conversion.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module adc_output_bus_mux
  import adc_bus_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Control pins
  input  wire logic              iface_sel_hi,
  input  wire logic              iface_sel_lo,
  input  wire logic              rd_n,
  input  wire logic              cs_n,
  input  wire logic              reset_pin,
  input  wire logic              ref_powerdown,
  input  wire logic              refbuf_powerdown,
  input  wire logic              config_sel_a,
  // Data bus pins
  input  wire logic [RES_W-1:0]  d_in,
  output logic [RES_W-1:0]       d_out,
  output logic [RES_W-1:0]       d_oe_n,
  // Analog and converter controls
  output logic                   ref_enable,
  output logic                   refbuf_enable,
  output logic                   conv_abort
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int CTL_W = 8;

  logic [CTL_W-1:0] ctl_s;
  logic [RES_W-1:0] din_s;
  logic [1:0]       mode_s;
  logic             rd_n_s;
  logic             cs_n_s;
  logic             rst_pin_s;
  logic             ref_pd_s;
  logic             buf_pd_s;
  logic             cfg_sel_s;

  pin_sync #(
    .W       (CTL_W),
    .RST_VAL (8'h0c)
  ) u_ctl_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({config_sel_a, refbuf_powerdown, ref_powerdown, reset_pin,
                cs_n, rd_n, iface_sel_hi, iface_sel_lo}),
    .sync_out (ctl_s)
  );

  pin_sync #(
    .W       (RES_W),
    .RST_VAL (18'h00000)
  ) u_din_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (d_in),
    .sync_out (din_s)
  );

  assign mode_s    = ctl_s[1:0];
  assign rd_n_s    = ctl_s[2];
  assign cs_n_s    = ctl_s[3];
  assign rst_pin_s = ctl_s[4];
  assign ref_pd_s  = ctl_s[5];
  assign buf_pd_s  = ctl_s[6];
  assign cfg_sel_s = ctl_s[7];

  // ----------------------------------------------------------------
  // Reset pin edge
  // ----------------------------------------------------------------
  logic rst_pin_q;
  logic rst_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_pin_q <= 1'b0;
    end else begin
      rst_pin_q <= rst_pin_s;
    end
  end

  assign rst_fall = rst_pin_q && !rst_pin_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_abort <= 1'b0;
    end else begin
      conv_abort <= rst_pin_s;
    end
  end

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic              wr_fire;
  logic              wr_hit;
  logic [RES_W-1:0]  result_q;
  logic [CFG_W-1:0]  cfg_q;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit  = (waddr_q[ADDR_W-1:2] == OFS_RESULT[ADDR_W-1:2]) ||
                   (waddr_q[ADDR_W-1:2] == OFS_CONFIG[ADDR_W-1:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_have_q     <= 1'b0;
      waddr_q       <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      aw_have_q     <= 1'b1;
      waddr_q       <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_have_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      w_have_q     <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Result and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_fall) begin
      result_q <= RESULT_RST;
    end else if (wr_fire && waddr_q[ADDR_W-1:2] == OFS_RESULT[ADDR_W-1:2]) begin
      if (wstrb_q[0]) result_q[7:0]   <= wdata_q[7:0];
      if (wstrb_q[1]) result_q[15:8]  <= wdata_q[15:8];
      if (wstrb_q[2]) result_q[17:16] <= wdata_q[17:16];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rst_fall) begin
      cfg_q <= CFG_RST;
    end else if (wr_fire && waddr_q[ADDR_W-1:2] == OFS_CONFIG[ADDR_W-1:2]) begin
      if (wstrb_q[0]) cfg_q <= wdata_q[CFG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Effective configuration
  // ----------------------------------------------------------------
  logic sw_cfg;
  logic ref_pd_eff;
  logic buf_pd_eff;
  logic coding_eff;
  logic buf_misuse;

  assign sw_cfg     = (mode_s == MODE_SERIAL) && !cfg_sel_s;
  assign ref_pd_eff = sw_cfg ? cfg_q[CFG_REF_PD] : ref_pd_s;
  assign buf_pd_eff = sw_cfg ? cfg_q[CFG_BUF_PD] : buf_pd_s;
  // Line 0 is data in mode 0, so coding then comes from the register
  assign coding_eff = (sw_cfg || mode_s == MODE_PAR18) ? cfg_q[CFG_CODING]
                                                        : din_s[0];
  // Internal reference in use with its buffer powered down
  assign buf_misuse = !ref_pd_eff && buf_pd_eff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_enable    <= 1'b0;
      refbuf_enable <= 1'b0;
    end else begin
      ref_enable    <= !ref_pd_eff;
      refbuf_enable <= !buf_pd_eff;
    end
  end

  // ----------------------------------------------------------------
  // Output bus
  // ----------------------------------------------------------------
  logic [RES_W-1:0] coded;
  logic [RES_W-1:0] lane_data;
  logic [RES_W-1:0] lane_drive;
  logic             bus_en;

  // Low coding select gives two's complement: MSB inverted
  assign coded  = {result_q[RES_W-1] ^ !coding_eff, result_q[RES_W-2:0]};
  assign bus_en = !rd_n_s && !cs_n_s;

  bus_lane_map u_map (
    .mode           (mode_s),
    .word_select    (din_s[1]),
    .byte_select_hi (din_s[2]),
    .word           (coded),
    .lane_data      (lane_data),
    .lane_drive     (lane_drive)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d_out  <= '0;
      d_oe_n <= OE_N_RST;
    end else begin
      d_out  <= bus_en ? (lane_data & lane_drive) : '0;
      d_oe_n <= bus_en ? ~lane_drive : OE_N_RST;
    end
  end

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] status_w;

  always_comb begin
    status_w                              = '0;
    status_w[ST_MODE_LSB+1:ST_MODE_LSB]   = mode_s;
    status_w[ST_BUS_EN]                   = bus_en;
    status_w[ST_REF_EN]                   = !ref_pd_eff;
    status_w[ST_BUF_EN]                   = !buf_pd_eff;
    status_w[ST_SW_CFG]                   = sw_cfg;
    status_w[ST_ABORT]                    = rst_pin_s;
    status_w[ST_BUF_MISUSE]               = buf_misuse;
    status_w[ST_CODING]                   = coding_eff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr[ADDR_W-1:2])
        OFS_RESULT[ADDR_W-1:2]: s_axi_rdata <= {14'h0000, result_q};
        OFS_CONFIG[ADDR_W-1:2]: s_axi_rdata <= {29'h00000000, cfg_q};
        OFS_STATUS[ADDR_W-1:2]: s_axi_rdata <= status_w;
        OFS_PINS[ADDR_W-1:2]:   s_axi_rdata <= {14'h0000, din_s};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// *** adc_output_bus_mux_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module adc_output_bus_mux_chk
  import adc_bus_pkg::*;
(
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Control pins
  input wire logic             iface_sel_hi,
  input wire logic             iface_sel_lo,
  input wire logic             rd_n,
  input wire logic             cs_n,
  input wire logic             reset_pin,
  input wire logic             ref_powerdown,
  input wire logic             refbuf_powerdown,
  input wire logic             config_sel_a,
  // Outputs
  input wire logic [RES_W-1:0] d_out,
  input wire logic [RES_W-1:0] d_oe_n,
  input wire logic             ref_enable,
  input wire logic             refbuf_enable,
  input wire logic             conv_abort
);
  // ----------------------------------------------------------------
  // Pin to output, three edges later
  // ----------------------------------------------------------------
  wire logic [1:0] mode   = {iface_sel_hi, iface_sel_lo};
  wire logic       bus_on = !rd_n && !cs_n;
  wire logic       hw_cfg = (mode != MODE_SERIAL) || config_sel_a;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bus_off_idle: assert property (!bus_on |-> ##3 (&d_oe_n))
    else $error("bus driven while deselected");
  a_released_zero: assert property ((d_out & d_oe_n) == '0)
    else $error("released line carries data");
  a_par_lanes:
    assert property ($past(aresetn) && bus_on && mode == MODE_PAR18 |-> ##3 d_oe_n == '0)
    else $error("parallel lanes wrong");
  a_word_lanes:
    assert property ($past(aresetn) && bus_on && mode == MODE_WORD16 |-> ##3 d_oe_n == 18'h00003)
    else $error("word lanes wrong");
  a_byte_lanes:
    assert property ($past(aresetn) && bus_on && mode == MODE_BYTE8 |-> ##3 d_oe_n == 18'h003ff)
    else $error("byte lanes wrong");
  a_serial_free: assert property (mode == MODE_SERIAL |-> ##3 (&d_oe_n))
    else $error("serial mode drives lines");
  a_ref_follow:
    assert property ($past(aresetn) && hw_cfg |-> ##3 ref_enable == !$past(ref_powerdown, 3))
    else $error("reference enable wrong");
  a_buf_follow:
    assert property ($past(aresetn) && hw_cfg |-> ##3 refbuf_enable == !$past(refbuf_powerdown, 3))
    else $error("buffer enable wrong");
  a_abort_level:
    assert property ($past(aresetn) |-> ##3 conv_abort == $past(reset_pin, 3))
    else $error("abort does not follow reset pin");

  c_byte_read: cover property (bus_on && mode == MODE_BYTE8);
  c_soft_cfg: cover property (!hw_cfg);
  c_abort: cover property ($rose(conv_abort));
endmodule

bind adc_output_bus_mux adc_output_bus_mux_chk i_adc_output_bus_mux_chk (
  .aclk, .aresetn, .iface_sel_hi, .iface_sel_lo, .rd_n, .cs_n, .reset_pin,
  .ref_powerdown, .refbuf_powerdown, .config_sel_a, .d_out, .d_oe_n,
  .ref_enable, .refbuf_enable, .conv_abort
);
`default_nettype wire

// *** adc_output_bus_mux_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
  end \
end

module adc_output_bus_mux_tb
  import adc_bus_pkg::*;
;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_arvalid = 1'b0;
  logic [1:0]        host_mode = 2'h0;
  logic [2:0]        host_sel = 3'h0;
  logic              rd_en = 1'b0;
  logic              cs_en = 1'b0;
  logic              ref_pd_req = 1'b0;
  logic              buf_pd_req = 1'b0;
  logic              config_sel_a = 1'b1;
  logic              reset_pin = 1'b0;
  wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]   s_axi_bresp, s_axi_rresp;
  wire logic [31:0]  s_axi_rdata;
  wire logic [17:0]  d_in, d_out, d_oe_n;
  wire logic         iface_sel_hi, iface_sel_lo, rd_n, cs_n, ref_powerdown, refbuf_powerdown;
  wire logic         ref_enable, refbuf_enable, conv_abort;
  int                err_count = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                seed = 27410;

  adc_output_bus_mux i_adc_output_bus_mux (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .iface_sel_hi, .iface_sel_lo,
    .rd_n, .cs_n, .reset_pin, .ref_powerdown, .refbuf_powerdown, .config_sel_a,
    .d_in, .d_out, .d_oe_n, .ref_enable, .refbuf_enable, .conv_abort
  );

  host_bus_model i_host_bus_model (
    .aclk, .host_mode, .host_sel, .rd_en, .cs_en, .ref_pd_req, .buf_pd_req, .d_out,
    .d_oe_n, .iface_sel_hi, .iface_sel_lo, .rd_n, .cs_n, .ref_powerdown,
    .refbuf_powerdown, .d_in
  );

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // Returns {line data, line release mask}
  function automatic logic [35:0] exp_bus(input logic [1:0] m, input logic [2:0] s,
                                          input logic [17:0] r, input logic cfg_cod);
    logic [17:0] w;
    logic [17:0] d;
    logic [17:0] e;
    w = (((m == MODE_PAR18) ? cfg_cod : s[0]) ? r : r ^ 18'h20000);
    d = '0;
    e = '0;
    if (m == MODE_PAR18) begin
      d = w;
      e = '1;
    end else if (m == MODE_WORD16) begin
      e = 18'h3fffc;
      d = s[1] ? {14'h0, w[1:0], 2'h0} : (w & e);
    end else if (m == MODE_BYTE8) begin
      e = 18'h3fc00;
      case ({s[1], s[2]})
        2'h0: d = w & e;
        2'h1: d = {w[9:2], 10'h0};
        2'h2: d = {6'h0, w[1:0], 10'h0};
        default: d = {w[1:0], 16'h0};
      endcase
    end
    return {d, ~e};
  endfunction

  initial begin
    logic [17:0] r;
    logic [35:0] x;
    logic [31:0] rd;
    logic [1:0]  resp;
    logic [2:0]  s;
    logic        cod;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int it = 0; it < 48; it++) begin
      r = 18'($random(seed));
      if (it < 4) r = it[1] ? '1 : '0;
      cod = 1'($random(seed));
      s = {it[3], it[2], 1'($random(seed))};
      axi_wr(OFS_RESULT, {14'h0, r}, resp);
      `CHK(resp, RESP_OKAY)
      axi_wr(OFS_CONFIG, {29'h0, cod, 2'h0}, resp);
      axi_rd(OFS_RESULT, rd, resp);
      `CHK(rd, {14'h0, r})
      host_mode <= it[1:0];
      host_sel <= s;
      rd_en <= 1'b1;
      cs_en <= 1'b1;
      repeat (5) @(posedge aclk);
      x = exp_bus(it[1:0], s, r, cod);
      `CHK(d_out, x[35:18])
      `CHK(d_oe_n, x[17:0])
      if (it[0]) rd_en <= 1'b0;
      else cs_en <= 1'b0;
      repeat (5) @(posedge aclk);
      `CHK(d_oe_n, '1)
      `CHK(d_out, '0)
    end
    $display("test lane mapping done");
    for (int i = 0; i < 4; i++) begin
      ref_pd_req <= i[0];
      buf_pd_req <= i[1];
      repeat (5) @(posedge aclk);
      `CHK(ref_enable, !i[0])
      `CHK(refbuf_enable, !(i[0] && i[1]))
    end
    $display("test hardware reference done");
    config_sel_a <= 1'b0;
    host_mode <= MODE_SERIAL;
    for (int i = 0; i < 4; i++) begin
      axi_wr(OFS_CONFIG, 32'(i), resp);
      ref_pd_req <= !i[0];
      buf_pd_req <= !i[1];
      repeat (5) @(posedge aclk);
      `CHK(ref_enable, !i[0])
      `CHK(refbuf_enable, !i[1])
      axi_rd(OFS_STATUS, rd, resp);
      `CHK(rd, ({23'h0, 1'b0, !i[0] && i[1], 1'b0, 1'b1, !i[1], !i[0], 1'b0, 2'h3}))
    end
    $display("test software config done");
    axi_wr(OFS_RESULT, 32'h2a5a5, resp);
    axi_wr(OFS_CONFIG, 32'h7, resp);
    reset_pin <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK(conv_abort, 1'b1)
    reset_pin <= 1'b0;
    repeat (5) @(posedge aclk);
    `CHK(conv_abort, 1'b0)
    `CHK(ref_enable, 1'b1)
    axi_rd(OFS_RESULT, rd, resp);
    `CHK(rd, 32'h0)
    axi_rd(OFS_CONFIG, rd, resp);
    `CHK(rd, 32'h0)
    axi_rd(12'h010, rd, resp);
    `CHK(resp, RESP_SLVERR)
    axi_wr(12'h020, 32'h1, resp);
    `CHK(resp, RESP_SLVERR)
    $display("test reset pin done");
    close_out;
  end
endmodule
`default_nettype wire

// *** bus_lane_map.sv ***
`timescale 1ns/1ps
`default_nettype none

module bus_lane_map
  import adc_bus_pkg::*;
(
  // Selection
  input  wire logic [1:0]       mode,
  input  wire logic             word_select,
  input  wire logic             byte_select_hi,
  // Coded result
  input  wire logic [RES_W-1:0] word,
  // Lane values and drive enables
  output logic      [RES_W-1:0] lane_data,
  output logic      [RES_W-1:0] lane_drive
);

  always_comb begin
    lane_data  = '0;
    lane_drive = '0;
    case (mode)
      MODE_PAR18: begin
        lane_data  = word;
        lane_drive = '1;
      end
      MODE_WORD16: begin
        // Lines 0 and 1 stay inputs
        lane_drive = 18'h3fffc;
        if (!word_select) begin
          lane_data[17:2] = word[17:2];
        end else begin
          lane_data[3:2] = word[1:0];
        end
      end
      MODE_BYTE8: begin
        // Lines 1..2 select, 3..9 released
        lane_drive = 18'h3fc00;
        case ({word_select, byte_select_hi})
          2'h0: lane_data[17:10] = word[17:10];
          2'h1: lane_data[17:10] = word[9:2];
          2'h2: lane_data[11:10] = word[1:0];
          default: lane_data[17:16] = word[1:0];
        endcase
      end
      default: begin
        // Upper lines belong to the serial engine; none driven here
        lane_drive = '0;
      end
    endcase
  end

endmodule

`default_nettype wire

// *** host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
  import adc_bus_pkg::*;
(
  // Clock
  input wire logic             aclk,
  // Bench requests
  input wire logic [1:0]       host_mode,
  input wire logic [2:0]       host_sel,
  input wire logic             rd_en,
  input wire logic             cs_en,
  input wire logic             ref_pd_req,
  input wire logic             buf_pd_req,
  // Device bus
  input wire logic [RES_W-1:0] d_out,
  input wire logic [RES_W-1:0] d_oe_n,
  output logic                 iface_sel_hi,
  output logic                 iface_sel_lo,
  output logic                 rd_n,
  output logic                 cs_n,
  output logic                 ref_powerdown,
  output logic                 refbuf_powerdown,
  output logic [RES_W-1:0]     d_in
);
  logic [RES_W-1:0] host_msk;
  logic [RES_W-1:0] float_q = 18'h2aaaa;

  // Floating lines toggle so stale levels never read back
  always @(posedge aclk) float_q <= ~float_q;

  assign host_msk = (host_mode == MODE_PAR18) ? 18'h0 :
                    (host_mode == MODE_BYTE8) ? 18'h7 : 18'h3;
  assign d_in = (~d_oe_n & d_out) | (d_oe_n & host_msk & {15'h0, host_sel}) |
                (d_oe_n & ~host_msk & float_q);
  assign {iface_sel_hi, iface_sel_lo} = host_mode;
  assign rd_n = !rd_en;
  assign cs_n = !cs_en;
  assign ref_powerdown = ref_pd_req;
  assign refbuf_powerdown = buf_pd_req && ref_pd_req;
endmodule
`default_nettype wire

// *** pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire
